// *** adc_dataway_map.svh ***
// Constants for the dataway function decoder of the eight-channel converter.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef ADC_DATAWAY_MAP_SVH
`define ADC_DATAWAY_MAP_SVH

// Function codes
`define FN_READ_RESULT 5'h00
`define FN_READ_CONFIG 5'h01
`define FN_READ_CLEAR 5'h02
`define FN_TEST_LAM 5'h08
`define FN_CLEAR 5'h09
`define FN_WRITE_CONFIG 5'h11
`define FN_WRITE_THRESH 5'h14
`define FN_LAM_DISABLE 5'h18
`define FN_SOFT_TRIGGER 5'h19
`define FN_LAM_ENABLE 5'h1a
`define FN_TEST_STATUS 5'h1b

// Subaddress values
`define SUB_PATTERN 4'h8
`define SUB_LAST_CHANNEL 4'h7

// Configuration word field positions
`define CFG_READY_BIT 0
`define CFG_ENABLE_BIT 1
`define CFG_MODE_LSB 2
`define CFG_GATE_LSB 4

// Reset values
`define CFG_RESET 8'h00
`define RESULT_RESET 12'h000
`define THRESH_RESET 8'h00

// Gate timing
`define GATE_STEP_NS 1000
`define CLK_PERIOD_NS 50
`define GATE_MIN_CODE 4'h1

`endif

// *** adc_dataway_pkg.sv ***
// Types shared by the dataway function decoder and its gate timer.
// Assumes the map header is reachable by bare name on the include path.
`include "adc_dataway_map.svh"

package adc_dataway_pkg;

  // Acquisition modes held in the configuration word
  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_EXTERNAL = 2'b01,
    MODE_SOFTWARE = 2'b10,
    MODE_SELF_TEST = 2'b11
  } acq_mode_t;

  // One dataway command cycle
  typedef struct packed {
    logic strobe;
    logic [4:0] func;
    logic [3:0] sub;
    logic [7:0] wdata;
  } dataway_cmd_t;

  // Command answer
  typedef struct packed {
    logic x;
    logic q;
    logic [11:0] rdata;
  } dataway_resp_t;

  // Result delivered by the converter sequencer
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [11:0] value;
  } conv_result_t;

endpackage

// *** gate_width_timer.sv ***
// Per-channel peak gate timer: turns the four-bit gate code into a gate pulse.
// Assumes a start pulse from the trigger logic on the same clock.
`timescale 1ns/1ps
`include "adc_dataway_map.svh"

module gate_width_timer
  import adc_dataway_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_start,
  input wire logic [3:0] i_gate_code,
  // Gate output
  output logic o_gate
);

  // Cycles in one gate step
  localparam logic [CNT_W-1:0] STEP_CYCLES =
    CNT_W'(`GATE_STEP_NS / `CLK_PERIOD_NS);

  logic [CNT_W-1:0] tick_q; // Cycles within the current step
  logic [3:0] steps_q; // Steps still to run
  logic [3:0] code_eff; // Code with 0 folded onto 1

  // Codes 0 and 1 both mean one step [RULE23]
  assign code_eff = (i_gate_code < `GATE_MIN_CODE) ? `GATE_MIN_CODE : i_gate_code;

  // Step counter; a start during a gate restarts it
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_q <= '0;
      steps_q <= 4'h0;
    end else if (i_start) begin
      tick_q <= STEP_CYCLES - CNT_W'(1);
      steps_q <= code_eff; // [RULE23]
    end else if (steps_q != 4'h0) begin
      if (tick_q == '0) begin
        tick_q <= STEP_CYCLES - CNT_W'(1);
        steps_q <= steps_q - 4'h1;
      end else begin
        tick_q <= tick_q - CNT_W'(1);
      end
    end
  end

  // Gate open while steps remain
  assign o_gate = (steps_q != 4'h0);

endmodule

// *** adc_function_decoder.sv ***
// Dataway function decoder and register set for an eight-channel peak converter.
// Assumes dataway lines are synchronised in the crate interface; Z and C arrive
// as one-cycle pulses on the reference clock, converter results likewise.
//
// Functional notes
// RULE1 - F0 reads result, nothing changes
// RULE2 - F1 A0-7 returns configuration word
// RULE3 - Config bit 0 shows live ready flag
// RULE4 - F1 A8 returns ready pattern
// RULE5 - Pattern read Q is OR of flags
// RULE6 - F2 reads result then clears channel
// RULE7 - F8 Q when LAM enabled and ready
// RULE8 - F9 or C clears results, LAM, lamp
// RULE9 - Z clears everything, disables LAM; code keeps thresholds on Z
// RULE10 - F17 writes config, W1 ignored
// RULE11 - W2 enables the channel
// RULE12 - W4 W3 select acquisition mode
// RULE13 - W5 to W8 give gate width
// RULE14 - F20 writes low/high thresholds by subaddress
// RULE15 - F24 disables LAM generation
// RULE16 - F25 triggers all stretchers
// RULE17 - F26 enables LAM generation
// RULE18 - F27 Q is OR of flags
// RULE19 - Subaddress ignored for global functions
// RULE20 - Controller follows setup and polling order
// RULE21 - Read-and-clear of all leaves device ready
// RULE22 - X on valid functions, Q unless tested
// RULE23 - Gate codes 0 and 1 both 1 us
// RULE24 - Stored result raises LAM when enabled
// RULE25 - LAM disabled after power-on
// RULE26 - Unlisted combinations: no X, Q, change
// RULE27 - Ready flag set on store, held
`timescale 1ns/1ps
`include "adc_dataway_map.svh"

module adc_function_decoder
  import adc_dataway_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int GATE_CNT_W = 10
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Dataway command and dataway-wide commands
  input wire dataway_cmd_t i_cmd,
  input wire logic i_dataway_clear,
  input wire logic i_dataway_init,
  // Dataway answer
  output dataway_resp_t o_resp,
  output logic o_lam,
  // Converter side
  input wire conv_result_t i_conv,
  input wire logic [NUM_CH-1:0] i_external_trigger_input,
  output logic [NUM_CH-1:0] o_chan_enable,
  output logic [2*NUM_CH-1:0] o_chan_mode,
  output logic [NUM_CH-1:0] o_stretch_trigger,
  output logic [NUM_CH-1:0] o_self_test,
  output logic [NUM_CH-1:0] o_gate,
  output logic [8*NUM_CH-1:0] o_low_level,
  output logic [8*NUM_CH-1:0] o_high_level,
  // Front panel
  output logic o_ready_lamp
);

  // Per-channel storage
  logic [7:0] channel_config_q [NUM_CH]; // Stored configuration, bit 0 unused
  logic [11:0] channel_result_q [NUM_CH]; // Conversion results
  logic [7:0] window_low_level_q [NUM_CH]; // Low window thresholds
  logic [7:0] window_high_level_q [NUM_CH]; // High window thresholds
  logic [NUM_CH-1:0] ready_q; // Data-ready flags, the ready pattern
  logic lam_enable_q; // LAM generation enable
  logic lam_pending_q; // Latched LAM request
  logic lamp_q; // Data-ready indicator
  logic soft_trig_q; // Software trigger pulse
  dataway_resp_t resp_q; // Registered answer
  // Trigger pins arrive from another clock domain
  logic [NUM_CH-1:0] ext_meta_q; // First stage, read only by the second
  logic [NUM_CH-1:0] ext_sync_q; // Second stage, safe to decode

  // Decoded command strobes
  logic chan_sub; // Subaddress names a channel
  logic [2:0] ch; // Selected channel
  logic any_ready; // OR of all ready flags
  logic do_read_result, do_read_config, do_read_pattern, do_read_clear;
  logic do_test_lam, do_clear, do_write_config, do_write_thresh;
  logic do_lam_off, do_soft_trig, do_lam_on, do_test_status;
  logic valid_fn; // Function/subaddress pair is listed

  assign chan_sub = (i_cmd.sub <= `SUB_LAST_CHANNEL);
  assign ch = i_cmd.sub[2:0];
  assign any_ready = |ready_q;

  // Command decode; global functions ignore subaddress [RULE19]
  // Every strobe is qualified here once, so the state processes below
  // never see a half-decoded function while the strobe is low
  always_comb begin
    do_read_result = i_cmd.strobe && i_cmd.func == `FN_READ_RESULT && chan_sub;
    do_read_config = i_cmd.strobe && i_cmd.func == `FN_READ_CONFIG && chan_sub;
    do_read_pattern = i_cmd.strobe && i_cmd.func == `FN_READ_CONFIG &&
                      i_cmd.sub == `SUB_PATTERN;
    do_read_clear = i_cmd.strobe && i_cmd.func == `FN_READ_CLEAR && chan_sub;
    do_test_lam = i_cmd.strobe && i_cmd.func == `FN_TEST_LAM; // [RULE19]
    do_clear = i_cmd.strobe && i_cmd.func == `FN_CLEAR; // [RULE19]
    do_write_config = i_cmd.strobe && i_cmd.func == `FN_WRITE_CONFIG && chan_sub;
    do_write_thresh = i_cmd.strobe && i_cmd.func == `FN_WRITE_THRESH; // Any of 16
    do_lam_off = i_cmd.strobe && i_cmd.func == `FN_LAM_DISABLE; // [RULE19]
    do_soft_trig = i_cmd.strobe && i_cmd.func == `FN_SOFT_TRIGGER; // [RULE19]
    do_lam_on = i_cmd.strobe && i_cmd.func == `FN_LAM_ENABLE; // [RULE19]
    do_test_status = i_cmd.strobe && i_cmd.func == `FN_TEST_STATUS; // [RULE19]
    // Unlisted pairs give no X and touch nothing [RULE26]
    valid_fn = do_read_result | do_read_config | do_read_pattern | do_read_clear |
               do_test_lam | do_clear | do_write_config | do_write_thresh |
               do_lam_off | do_soft_trig | do_lam_on | do_test_status;
  end

  // Trigger pin synchroniser; costs two cycles of trigger latency
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_meta_q <= '0;
      ext_sync_q <= '0;
    end else begin
      ext_meta_q <= i_external_trigger_input;
      ext_sync_q <= ext_meta_q;
    end
  end

  // Ready flags: set on store, cleared by F2, F9, C, Z
  // A store beats a same-cycle F2, F9 or C so no result is lost; Z beats all
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_q <= '0;
    end else if (i_dataway_init) begin
      ready_q <= '0; // [RULE9]
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (i_conv.valid && i_conv.chan == 3'(i)) begin
          ready_q[i] <= 1'b1; // Store wins [RULE27]
        end else if (i_dataway_clear || do_clear) begin
          ready_q[i] <= 1'b0; // [RULE8]
        end else if (do_read_clear && ch == 3'(i)) begin
          ready_q[i] <= 1'b0; // [RULE6] [RULE21]
        end
      end
    end
  end

  // Results; F0 reads leave them alone [RULE1]
  // Same priority as the ready flags, so a flag never outlives its result
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_CH; i++) channel_result_q[i] <= `RESULT_RESET;
    end else if (i_dataway_init) begin
      for (int i = 0; i < NUM_CH; i++) channel_result_q[i] <= `RESULT_RESET; // [RULE9]
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (i_conv.valid && i_conv.chan == 3'(i)) begin
          channel_result_q[i] <= i_conv.value; // Store wins over C and F9 [RULE27]
        end else if (i_dataway_clear || do_clear) begin
          channel_result_q[i] <= `RESULT_RESET; // [RULE8]
        end else if (do_read_clear && ch == 3'(i)) begin
          channel_result_q[i] <= `RESULT_RESET; // [RULE6]
        end
      end
    end
  end

  // Configuration words; W1 never stored [RULE10]
  // Only reset and Z clear them; C keeps the setup for the next acquisition
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_CH; i++) channel_config_q[i] <= `CFG_RESET;
    end else if (i_dataway_init) begin
      for (int i = 0; i < NUM_CH; i++) channel_config_q[i] <= `CFG_RESET; // [RULE9]
    end else if (do_write_config) begin
      channel_config_q[ch] <= {i_cmd.wdata[7:1], 1'b0}; // [RULE10]
    end
  end

  // Thresholds; Z leaves them untouched
  // Only power-on reset clears them, so a Z keeps the window settings
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        window_low_level_q[i] <= `THRESH_RESET;
        window_high_level_q[i] <= `THRESH_RESET;
      end
    end else if (do_write_thresh) begin
      // Odd subaddress is high level of channel sub/2 [RULE14]
      if (i_cmd.sub[0]) begin
        window_high_level_q[i_cmd.sub[3:1]] <= i_cmd.wdata;
      end else begin
        window_low_level_q[i_cmd.sub[3:1]] <= i_cmd.wdata;
      end
    end
  end

  // LAM enable: off at reset and on Z, F24 off, F26 on
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lam_enable_q <= 1'b0; // [RULE25]
    end else if (i_dataway_init || do_lam_off) begin
      lam_enable_q <= 1'b0; // [RULE9] [RULE15]
    end else if (do_lam_on) begin
      lam_enable_q <= 1'b1; // [RULE17]
    end
  end

  // Pending LAM: raised by a store while enabled, dropped with the data
  // A store in the same cycle as C or F9 keeps the request, so the new
  // result is still announced; Z always wins
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lam_pending_q <= 1'b0;
    end else if (i_conv.valid && lam_enable_q && !i_dataway_init) begin
      lam_pending_q <= 1'b1; // Store wins over clear [RULE24]
    end else if (i_dataway_init || i_dataway_clear || do_clear || !lam_enable_q) begin
      lam_pending_q <= 1'b0; // [RULE8] [RULE9] [RULE15]
    end else if (!any_ready) begin
      lam_pending_q <= 1'b0; // Last flag read out [RULE21]
    end
  end

  // Indicator lamp follows stored data
  // The lamp is shared, so any F2 puts it out even if other flags remain
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lamp_q <= 1'b0;
    end else if (i_conv.valid && !i_dataway_init) begin
      lamp_q <= 1'b1; // Store wins except over Z [RULE27]
    end else if (i_dataway_init || i_dataway_clear || do_clear || do_read_clear) begin
      lamp_q <= 1'b0; // [RULE6] [RULE8] [RULE9]
    end
  end

  // Software trigger to every stretcher, one cycle
  // Registered so the pulse is clean although the decode is combinational
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      soft_trig_q <= 1'b0;
    end else begin
      soft_trig_q <= do_soft_trig; // [RULE16]
    end
  end

  // Answer: data, X on valid, Q per function
  // Held for one cycle; the read lines fall back to zero when idle
  // so a stale word never looks like a fresh answer
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      resp_q <= '0;
    end else begin
      resp_q.x <= valid_fn; // [RULE22] [RULE26]
      resp_q.rdata <= 12'h000;
      if (do_test_lam) begin
        resp_q.q <= lam_enable_q && any_ready; // [RULE7]
      end else if (do_read_pattern || do_test_status) begin
        resp_q.q <= any_ready; // [RULE5] [RULE18]
      end else begin
        resp_q.q <= valid_fn; // [RULE22]
      end
      if (do_read_result || do_read_clear) begin
        resp_q.rdata <= channel_result_q[ch]; // [RULE1] [RULE6]
      end else if (do_read_config) begin
        // Bit 0 shows the live flag [RULE2] [RULE3]
        resp_q.rdata <= {4'h0, channel_config_q[ch][7:1], ready_q[ch]};
      end else if (do_read_pattern) begin
        resp_q.rdata <= {4'h0, ready_q[7:0]}; // [RULE4]
      end
    end
  end

  // Per-channel configuration fan-out and gate timers
  // Auto mode starts its gate on the analog side, not here
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    logic start; // Gate start for this channel
    acq_mode_t mode; // Decoded mode
    assign mode = acq_mode_t'(channel_config_q[g][`CFG_MODE_LSB +: 2]); // [RULE12]
    assign o_chan_enable[g] = channel_config_q[g][`CFG_ENABLE_BIT]; // [RULE11]
    assign o_chan_mode[2*g +: 2] = mode;
    assign o_self_test[g] = (mode == MODE_SELF_TEST);
    assign o_stretch_trigger[g] = soft_trig_q; // All channels [RULE16]
    assign o_low_level[8*g +: 8] = window_low_level_q[g];
    assign o_high_level[8*g +: 8] = window_high_level_q[g];
    // Start only when enabled and the result slot is empty
    // A full slot ignores triggers until F2, F9, C or Z empties it
    assign start = o_chan_enable[g] && !ready_q[g] &&
                   (((mode == MODE_SOFTWARE || mode == MODE_SELF_TEST) && soft_trig_q) ||
                    (mode == MODE_EXTERNAL && ext_sync_q[g]));
    gate_width_timer #(
      .CNT_W(GATE_CNT_W)
    ) u_gate (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_start(start),
      .i_gate_code(channel_config_q[g][`CFG_GATE_LSB +: 4]), // [RULE13]
      .o_gate(o_gate[g])
    );
  end

  // Outputs
  // LAM gated by the enable so F24 silences a pending request at once
  assign o_resp = resp_q;
  assign o_lam = lam_pending_q && lam_enable_q; // [RULE24]
  assign o_ready_lamp = lamp_q;

endmodule

// *** adc_function_decoder_properties.sv ***
// Checker: answer timing and register effects of the dataway decoder.
// Assumes it is bound to adc_function_decoder with eight channels.
`timescale 1ns/1ps
module adc_function_decoder_properties
  import adc_dataway_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int GATE_CNT_W = 10
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Dataway
  input wire dataway_cmd_t i_cmd,
  input wire logic i_dataway_clear,
  input wire logic i_dataway_init,
  input wire dataway_resp_t o_resp,
  input wire logic o_lam,
  // Converter and panel
  input wire conv_result_t i_conv,
  input wire logic [NUM_CH-1:0] o_chan_enable,
  input wire logic [2*NUM_CH-1:0] o_chan_mode,
  input wire logic [NUM_CH-1:0] o_stretch_trigger,
  input wire logic [8*NUM_CH-1:0] o_low_level,
  input wire logic [8*NUM_CH-1:0] o_high_level,
  input wire logic o_ready_lamp
);
  dataway_cmd_t cmd_q; // Command of the previous cycle
  logic [4:0] fn; // Strobed function, else an unused code
  assign fn = i_cmd.strobe ? i_cmd.func : 5'h1f;
  // Previous command, so write checks see what was written
  always_ff @(posedge i_ref_clk) cmd_q <= i_cmd;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  property p_pat; fn == 5'h01 && i_cmd.sub == 4'h8 |=> o_resp.q == |o_resp.rdata; endproperty
  a_pat: assert property (p_pat) else $error("pattern q wrong");
  property p_trg; fn == 5'h19 |=> &o_stretch_trigger ##1 o_stretch_trigger == '0; endproperty
  a_trg: assert property (p_trg) else $error("trigger pulse wrong");
  property p_clr; i_dataway_clear && !i_conv.valid |=> !o_ready_lamp && !o_lam; endproperty
  a_clr: assert property (p_clr) else $error("clear left state");
  property p_ini; i_dataway_init |=> o_chan_enable == '0 && o_chan_mode == '0 && !o_lam; endproperty
  a_ini: assert property (p_ini) else $error("init left state");
  property p_off; fn == 5'h18 |=> !o_lam; endproperty
  a_off: assert property (p_off) else $error("lam after disable");
  property p_sto; i_conv.valid && !i_dataway_init |=> o_ready_lamp; endproperty
  a_sto: assert property (p_sto) else $error("store left lamp off");
  property p_cfg;
    fn == 5'h11 && i_cmd.sub < 4'h8 && !i_dataway_init |=>
      {o_chan_mode[2*cmd_q.sub[2:0] +: 2], o_chan_enable[cmd_q.sub[2:0]]} == cmd_q.wdata[3:1];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config not applied");
  property p_thr;
    fn == 5'h14 |=> cmd_q.wdata == (cmd_q.sub[0] ? o_high_level[8*cmd_q.sub[3:1] +: 8]
      : o_low_level[8*cmd_q.sub[3:1] +: 8]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not applied");
  c_poll: cover property (fn == 5'h08 ##1 o_resp.q);
  c_rdclr: cover property (fn == 5'h02 ##1 o_resp.rdata != 12'h000);
  c_clr: cover property (i_dataway_clear ##1 o_chan_enable != '0);
endmodule

bind adc_function_decoder adc_function_decoder_properties #(
  .NUM_CH(NUM_CH), .GATE_CNT_W(GATE_CNT_W)) adc_function_decoder_properties_inst (
  .i_ref_clk, .i_reset_n, .i_cmd, .i_dataway_clear, .i_dataway_init, .o_resp, .o_lam,
  .i_conv, .o_chan_enable, .o_chan_mode, .o_stretch_trigger, .o_low_level, .o_high_level,
  .o_ready_lamp);

// *** camac_crate_model.sv ***
// Crate controller model: one dataway cycle at a time, C and Z pulses.
// Assumes the decoder answers on the clock after the strobe.
`timescale 1ns/1ps
module camac_crate_model
  import adc_dataway_pkg::*;
(
  // Clock and answer
  input wire logic i_ref_clk,
  input wire dataway_resp_t i_resp,
  // Command lines
  output dataway_cmd_t o_cmd = '0,
  output logic o_clear = 1'b0,
  output logic o_init = 1'b0
);
  // Fields held with strobe, inverted once released so stale values show
  task automatic run(input logic [4:0] f, input logic [3:0] s, input logic [7:0] w,
                     output dataway_resp_t r);
    @(posedge i_ref_clk);
    o_cmd <= '{1'b1, f, s, w};
    @(posedge i_ref_clk);
    o_cmd <= '{1'b0, ~f, ~s, ~w};
    #1 r = i_resp;
  endtask
  // One-cycle C (z low) or Z (z high)
  task automatic pulse(input logic z);
    @(posedge i_ref_clk);
    o_clear <= ~z;
    o_init <= z;
    @(posedge i_ref_clk);
    o_clear <= 1'b0;
    o_init <= 1'b0;
  endtask
endmodule

// *** adc_function_decoder_tb_top.sv ***
// Testbench: crate model runs setup, acquisition, clears and resets.
// Assumes answers one clock after each strobe and default parameters.
`timescale 1ns/1ps
module adc_function_decoder_tb_top
  import adc_dataway_pkg::*;
;
  logic i_ref_clk;
  logic i_reset_n;
  dataway_cmd_t cmd; // Crate command
  logic clr, init; // C and Z pulses
  dataway_resp_t resp, r; // Live and taken answer
  conv_result_t conv; // Converter store
  logic lam, lamp;
  logic [7:0] ext = '0; // Trigger pins, driven by one process only
  logic [7:0] en, trig, tst, gate, rdy;
  logic [15:0] mode;
  logic [63:0] low, high, lo_e, hi_e;
  logic [11:0] res [8]; // Expected results
  logic [7:0] cfg [8]; // Expected configs
  logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hf}; // Gate codes, both shortest and longest
  logic [31:0] seed = 32'h31;
  logic [11:0] v;
  int miscompares = 0, n_compared = 0, cycles = 0, n;
  // 20 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  adc_function_decoder adc_function_decoder_inst (.i_ref_clk, .i_reset_n, .i_cmd(cmd),
    .i_dataway_clear(clr), .i_dataway_init(init), .o_resp(resp), .o_lam(lam),
    .i_conv(conv), .i_external_trigger_input(ext), .o_chan_enable(en), .o_chan_mode(mode),
    .o_stretch_trigger(trig), .o_self_test(tst), .o_gate(gate), .o_low_level(low),
    .o_high_level(high), .o_ready_lamp(lamp));
  camac_crate_model camac_crate_model_inst (.i_ref_clk, .i_resp(resp), .o_cmd(cmd),
    .o_clear(clr), .o_init(init));
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] rs();
    return 4'(rnd());
  endfunction
  // Config read back: bit 0 is the live ready flag
  function automatic logic [13:0] cfg_rd(input logic [7:0] c, input logic f);
    return {2'b11, 4'h0, c[7:1], f};
  endfunction
  // Gate clocks; codes 0 and 1 share one step
  function automatic int gate_len(input logic [3:0] c);
    return (c < 4'h2 ? 1 : int'(c)) * 20;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic op(input logic [4:0] f, input logic [3:0] s, input logic [7:0] w,
                    input logic [13:0] e);
    camac_crate_model_inst.run(f, s, w, r);
    check(r, e);
  endtask
  // Converter store pulse, mirrored in the expectations
  task automatic store(input logic [2:0] ch, input logic [11:0] val);
    @(posedge i_ref_clk);
    conv <= '{1'b1, ch, val};
    @(posedge i_ref_clk);
    conv <= '{1'b0, ~ch, ~val};
    res[ch] = val;
    rdy[ch] = 1'b1;
  endtask
  // Trigger lines keep moving; a hang is cut off
  always @(posedge i_ref_clk) begin
    ext <= {ext[6:0], ~ext[7]};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    i_reset_n = 1'b0;
    conv = '0;
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    store(3'h1, 12'habc);
    op(5'h08, rs(), 8'h00, 14'h2000);
    op(5'h1b, rs(), 8'h00, 14'h3000);
    camac_crate_model_inst.pulse(1'b1); // Reset first
    rdy = '0;
    foreach (res[i]) res[i] = 12'h000;
    op(5'h01, 4'h8, 8'h00, 14'h2000);
    for (int i = 0; i < 16; i++) begin
      v = 12'(rnd());
      if (i[0]) hi_e[8*(i/2) +: 8] = v[7:0];
      else lo_e[8*(i/2) +: 8] = v[7:0];
      op(5'h14, 4'(i), v[7:0], 14'h3000);
    end
    check(low, lo_e);
    check(high, hi_e);
    op(5'h1a, rs(), 8'h00, 14'h3000); // After reset
    for (int i = 0; i < 8; i++) begin
      v = 12'(rnd());
      cfg[i] = {v[7:4], 2'(i), v[1:0]};
      op(5'h11, 4'(i), cfg[i], 14'h3000);
      check({mode[2*i +: 2], en[i]}, cfg[i][3:1]);
      op(5'h01, 4'(i), 8'h00, cfg_rd(cfg[i], 1'b0));
    end
    check(tst, 8'h88); // Channels 3 and 7 in test mode
    camac_crate_model_inst.run(5'h11, 4'h8, 8'hff, r);
    check(r[13:12], 2'b00);
    camac_crate_model_inst.run(5'h03, 4'h0, 8'hff, r);
    check(r[13:12], 2'b00);
    op(5'h01, 4'h0, 8'h00, cfg_rd(cfg[0], 1'b0));
    // Software mode, channel 0 enabled, gate measured
    for (int k = 0; k < 3; k++) begin
      cfg[0] = {codes[k], 4'ha};
      op(5'h11, 4'h0, cfg[0], 14'h3000);
      op(5'h19, rs(), 8'h00, 14'h3000); // Soft mode needs it
      check(trig, 8'hff); // Pulse to every stretcher
      n = 0;
      repeat (400) begin
        @(negedge i_ref_clk);
        n += int'(gate[0]);
      end
      check(n, gate_len(codes[k]));
    end
    repeat (12) begin
      v = 12'(rnd());
      store(3'(rnd()), v);
    end
    op(5'h08, rs(), 8'h00, 14'h3000); // Poll
    check(lam, 1'b1);
    op(5'h01, 4'h8, 8'h00, {2'b11, 4'h0, rdy});
    for (int i = 0; i < 8; i++) begin
      op(5'h01, 4'(i), 8'h00, cfg_rd(cfg[i], rdy[i]));
      op(5'h00, 4'(i), 8'h00, {2'b11, res[i]});
      op(5'h02, 4'(i), 8'h00, {2'b11, res[i]}); // Fetch
      res[i] = 12'h000;
      rdy[i] = 1'b0;
    end
    op(5'h01, 4'h8, 8'h00, 14'h2000);
    check({lam, lamp}, 2'b00);
    op(5'h18, rs(), 8'h00, 14'h3000);
    store(3'h3, 12'h5a5);
    op(5'h08, rs(), 8'h00, 14'h2000);
    op(5'h1b, rs(), 8'h00, 14'h3000);
    camac_crate_model_inst.pulse(1'b0);
    op(5'h00, 4'h3, 8'h00, 14'h3000);
    op(5'h01, 4'h0, 8'h00, cfg_rd(cfg[0], 1'b0));
    store(3'h5, 12'h3c3);
    op(5'h09, rs(), 8'h00, 14'h3000);
    op(5'h01, 4'h8, 8'h00, 14'h2000);
    op(5'h1a, rs(), 8'h00, 14'h3000);
    camac_crate_model_inst.pulse(1'b1);
    store(3'h2, 12'h7e7);
    op(5'h08, rs(), 8'h00, 14'h2000);
    op(5'h01, 4'h2, 8'h00, 14'h3001);
    check(low, lo_e);
    finish_test();
  end
endmodule
